/* File: irl_core_model.sv */
// Processor core model: acknowledges forwarded requests.
// Assumes irq_to_core is registered on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module irl_core_model (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic irq_to_core,
	input wire logic [3:0] ack_delay,
	output logic core_ack
);
	logic [3:0] wait_reg;
	// One-cycle ack while a request stands, after ack_delay cycles
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wait_reg <= 4'h0;
			core_ack <= 1'b0;
		end else begin
			core_ack <= irq_to_core && !core_ack && (wait_reg >= ack_delay);
			wait_reg <= (irq_to_core && !core_ack) ? wait_reg + 4'h1 : 4'h0;
		end
	end
endmodule : irl_core_model
`default_nettype wire

/* File: irl_pending_bit.sv */
// One pending bit: hardware set, software write, core acknowledge.
// Assumes all inputs are on the system clock.
`timescale 1ns/100ps
`default_nettype none
module irl_pending_bit (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hw_set,
	input wire logic sw_wr,
	input wire logic sw_val,
	input wire logic ack,
	output logic pending
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pending <= 1'b0;
		end else if (hw_set) begin
			pending <= 1'b1;
		end else if (sw_wr) begin
			pending <= sw_val;
		end else if (ack) begin
			pending <= 1'b0;
		end
	end

	a_hw_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
		hw_set |=> pending)
		else $error("hardware set lost");
	a_ack_clears: assert property (@(posedge clk) disable iff (!rst_n)
		ack && !hw_set && !sw_wr |=> !pending)
		else $error("acknowledge did not clear");
	a_sw_write: assert property (@(posedge clk) disable iff (!rst_n)
		sw_wr && !hw_set |=> pending == $past(sw_val))
		else $error("software write not applied");
endmodule : irl_pending_bit
`default_nettype wire

/* File: irl_pkg.sv */
// Package for the interrupt request latch: register map, fields, types.
// Assumes a single 100 MHz system clock and a plain strobe register port.
package irl_pkg;
	localparam logic [11:0] ADDR_BANK0 = 12'hfc0;
	localparam logic [11:0] ADDR_EN0_HIGH = 12'hfc1;
	localparam logic [11:0] ADDR_EN0_LOW = 12'hfc2;
	localparam logic [11:0] ADDR_BANK1 = 12'hfc3;
	localparam logic [11:0] ADDR_EN1_HIGH = 12'hfc4;
	localparam logic [11:0] ADDR_EN1_LOW = 12'hfc5;
	localparam logic [11:0] ADDR_BANK2 = 12'hfc6;
	localparam logic [11:0] ADDR_EN2_HIGH = 12'hfc7;
	localparam logic [11:0] ADDR_EN2_LOW = 12'hfc8;
	localparam logic [11:0] ADDR_CONTROL = 12'hfcf;
	localparam int CONTROL_GIE_BIT = 7;
	localparam logic [7:0] BANK0_MASK = 8'h79;
	localparam logic [7:0] BANK1_MASK = 8'hff;
	localparam logic [7:0] BANK2_MASK = 8'h0f;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam int NUM_SOURCES = 24;
	localparam logic [4:0] VEC_NONE = 5'h1f;
	localparam logic [4:0] VEC_WATCHDOG = 5'h1e;
	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} irl_bus_type;
	typedef struct packed {
		logic [3:0] portc;
		logic [7:0] porta;
		logic timer1;
		logic timer0;
		logic serial_rx;
		logic serial_tx;
		logic converter;
	} irl_sources_type;
endpackage : irl_pkg

/* File: irl_top.sv */
// Interrupt request latch: pending banks, enables, level arbiter, core handshake.
// Assumes sources and core on ref_clk; watchdog level is asynchronous.
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module irl_top (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire irl_pkg::irl_bus_type bus,
	output logic [7:0] rdata,
	input wire irl_pkg::irl_sources_type src,
	input wire logic watchdog_req,
	input wire logic core_ack,
	output logic irq_to_core,
	output logic [4:0] irq_vector,
	output logic global_interrupt_enable
);
	localparam int N = irl_pkg::NUM_SOURCES;
	logic rst_meta_reg, rst_sync_reg;
	logic wd_meta_reg, wd_sync_reg;
	logic [7:0] pending_requests_bank0, pending_requests_bank1, pending_requests_bank2;
	logic [7:0] en_high_reg [3];
	logic [7:0] en_low_reg [3];
	logic [N-1:0] hw_set, sw_wr, sw_val, ack_vec, pend;
	logic [N-1:0] en_hi, en_lo;
	logic [4:0] win_next;
	logic [1:0] win_lvl;
	logic ack_ok;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			wd_meta_reg <= 1'b0;
			wd_sync_reg <= 1'b0;
		end else begin
			wd_meta_reg <= watchdog_req;
			wd_sync_reg <= wd_meta_reg;
		end
	end

	// Flat source map, index = bank*8 + bit
	always_comb begin
		hw_set = '0;
		hw_set[6] = src.timer1;
		hw_set[5] = src.timer0;
		hw_set[4] = src.serial_rx;
		hw_set[3] = src.serial_tx;
		hw_set[0] = src.converter;
		hw_set[15:8] = src.porta;
		hw_set[19:16] = src.portc;
	end

	always_comb begin
		sw_wr = '0;
		sw_val = {8'h00, bus.wdata, bus.wdata};
		if (bus.wr) begin
			unique case (bus.addr)
				irl_pkg::ADDR_BANK0: sw_wr[7:0] = irl_pkg::BANK0_MASK;
				irl_pkg::ADDR_BANK1: sw_wr[15:8] = irl_pkg::BANK1_MASK;
				irl_pkg::ADDR_BANK2: sw_wr[23:16] = irl_pkg::BANK2_MASK;
				default: sw_wr = '0;
			endcase
		end
		sw_val[23:16] = bus.wdata;
	end

	generate
		for (genvar i = 0; i < N; i++) begin : g_bit
			irl_pending_bit u_bit (
				.clk(ref_clk),
				.rst_n(rst_sync_reg),
				.hw_set(hw_set[i]),
				.sw_wr(sw_wr[i]),
				.sw_val(sw_val[i]),
				.ack(ack_vec[i]),
				.pending(pend[i])
			);
		end
	endgenerate

	assign pending_requests_bank0 = pend[7:0];
	assign pending_requests_bank1 = pend[15:8];
	assign pending_requests_bank2 = pend[23:16];
	assign en_hi = {en_high_reg[2], en_high_reg[1], en_high_reg[0]};
	assign en_lo = {en_low_reg[2], en_low_reg[1], en_low_reg[0]};

	always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			for (int b = 0; b < 3; b++) begin
				en_high_reg[b] <= irl_pkg::RESET_VALUE;
				en_low_reg[b] <= irl_pkg::RESET_VALUE;
			end
		end else if (bus.wr) begin
			unique case (bus.addr)
				irl_pkg::ADDR_EN0_HIGH: en_high_reg[0] <= bus.wdata;
				irl_pkg::ADDR_EN0_LOW: en_low_reg[0] <= bus.wdata & irl_pkg::BANK0_MASK;
				irl_pkg::ADDR_EN1_HIGH: en_high_reg[1] <= bus.wdata;
				irl_pkg::ADDR_EN1_LOW: en_low_reg[1] <= bus.wdata;
				irl_pkg::ADDR_EN2_HIGH: en_high_reg[2] <= bus.wdata;
				irl_pkg::ADDR_EN2_LOW: en_low_reg[2] <= bus.wdata;
				default: ;
			endcase
		end
	end

	// Level then fixed order; lower bank wins, then higher bit within the bank
	always_comb begin
		logic [1:0] lvl;
		logic [4:0] idx;
		lvl = 2'd0;
		idx = 5'd0;
		win_next = irl_pkg::VEC_NONE;
		win_lvl = 2'd0;
		for (int k = 0; k < N; k++) begin
			idx = (k < 8) ? 5'(7 - k) : (k < 16) ? 5'(23 - k) : 5'(39 - k);
			lvl = {en_hi[idx], en_lo[idx]};
			if (pend[idx] && lvl > win_lvl) begin
				win_lvl = lvl;
				win_next = idx;
			end
		end
	end

	assign ack_ok = core_ack && irq_to_core;
	always_comb begin
		ack_vec = '0;
		if (ack_ok && irq_vector != irl_pkg::VEC_WATCHDOG && irq_vector != irl_pkg::VEC_NONE) begin
			ack_vec[irq_vector] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			global_interrupt_enable <= 1'b0;
		end else if (ack_ok) begin
			global_interrupt_enable <= 1'b0;
		end else if (bus.wr && bus.addr == irl_pkg::ADDR_CONTROL) begin
			global_interrupt_enable <= bus.wdata[irl_pkg::CONTROL_GIE_BIT];
		end
	end

	// Forward to core; watchdog bypasses per-source enables and pending bits but needs the global enable
	always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			irq_to_core <= 1'b0;
			irq_vector <= irl_pkg::VEC_NONE;
		end else if (ack_ok) begin
			irq_to_core <= 1'b0;
			irq_vector <= irl_pkg::VEC_NONE;
		end else if (global_interrupt_enable && wd_sync_reg) begin
			irq_to_core <= 1'b1;
			irq_vector <= irl_pkg::VEC_WATCHDOG;
		end else if (global_interrupt_enable && win_next != irl_pkg::VEC_NONE) begin
			irq_to_core <= 1'b1;
			irq_vector <= win_next;
		end else begin
			irq_to_core <= 1'b0;
			irq_vector <= irl_pkg::VEC_NONE;
		end
	end

	// Reads: pending bits always visible for polling
	always_ff @(posedge ref_clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			unique case (bus.addr)
				irl_pkg::ADDR_BANK0: rdata <= pending_requests_bank0;
				irl_pkg::ADDR_BANK1: rdata <= pending_requests_bank1;
				irl_pkg::ADDR_BANK2: rdata <= pending_requests_bank2;
				irl_pkg::ADDR_EN0_HIGH: rdata <= en_high_reg[0];
				irl_pkg::ADDR_EN0_LOW: rdata <= en_low_reg[0];
				irl_pkg::ADDR_EN1_HIGH: rdata <= en_high_reg[1];
				irl_pkg::ADDR_EN1_LOW: rdata <= en_low_reg[1];
				irl_pkg::ADDR_EN2_HIGH: rdata <= en_high_reg[2];
				irl_pkg::ADDR_EN2_LOW: rdata <= en_low_reg[2];
				irl_pkg::ADDR_CONTROL: rdata <= {global_interrupt_enable, 7'h00};
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	a_no_fwd_disabled: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
		!global_interrupt_enable && !wd_sync_reg |=> !irq_to_core)
		else $error("forwarded while disabled");
	a_ack_drops_gie: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
		ack_ok |=> !global_interrupt_enable && !irq_to_core)
		else $error("enable kept after acknowledge");
	a_timer1_capture: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
		src.timer1 |=> pending_requests_bank0[6])
		else $error("timer 1 request not captured");
	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
		pending_requests_bank0[7] == 1'b0 && pending_requests_bank0[2:1] == 2'h0 &&
		pending_requests_bank2[7:4] == 4'h0)
		else $error("reserved pending bit set");
	a_watchdog_fwd: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
		global_interrupt_enable && wd_sync_reg && !ack_ok |=> irq_vector == irl_pkg::VEC_WATCHDOG)
		else $error("watchdog not forwarded");
	a_level_order: assert property (@(posedge ref_clk) disable iff (!rst_sync_reg)
		global_interrupt_enable && !wd_sync_reg && !ack_ok && win_next != irl_pkg::VEC_NONE
		|=> irq_vector == $past(win_next))
		else $error("wrong winner forwarded");
	c_ack_seen: cover property (@(posedge ref_clk) disable iff (!rst_sync_reg) ack_ok);
	c_watchdog: cover property (@(posedge ref_clk) disable iff (!rst_sync_reg)
		irq_vector == irl_pkg::VEC_WATCHDOG);
	c_sw_set: cover property (@(posedge ref_clk) disable iff (!rst_sync_reg)
		bus.wr && bus.addr == irl_pkg::ADDR_BANK1 && bus.wdata != 8'h00);
endmodule : irl_top
`default_nettype wire

/* File: test_irl_top.sv */
// Testbench for the interrupt request latch beside a core model.
// Assumes register port and sources are driven on ref_clk.
`timescale 1ns/100ps
`default_nettype none
module test_irl_top;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	irl_pkg::irl_bus_type bus = '0;
	irl_pkg::irl_sources_type src = '0;
	logic watchdog_req = 1'b0;
	logic [3:0] ack_delay = 4'h0;
	logic core_ack;
	logic [7:0] rdata;
	logic irq_to_core;
	logic [4:0] irq_vector;
	logic global_interrupt_enable;
	int n_fail = 0;
	int check_count = 0;
	logic [11:0] banks [3] = '{12'hfc0, 12'hfc3, 12'hfc6};
	logic [7:0] masks [3] = '{8'h79, 8'hff, 8'h0f};
	logic [4:0] order [4] = '{5'h05, 5'h04, 5'h08, 5'h06};
	irl_top u_irl_top (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus), .rdata(rdata),
		.src(src), .watchdog_req(watchdog_req), .core_ack(core_ack),
		.irq_to_core(irq_to_core), .irq_vector(irq_vector),
		.global_interrupt_enable(global_interrupt_enable));
	irl_core_model u_irl_core_model (.ref_clk(ref_clk), .arst_n(arst_n),
		.irq_to_core(irq_to_core), .ack_delay(ack_delay), .core_ack(core_ack));
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic end_of_test();
		if (n_fail == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// One bus cycle beside optional source pulses
	task automatic cyc(input logic [11:0] a, input logic [7:0] d, input logic w,
			input logic r, input irl_pkg::irl_sources_type s);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: d, wr: w, rd: r};
		src <= s;
		@(posedge ref_clk);
		bus <= '0;
		src <= '0;
		#1;
	endtask : cyc
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		cyc(a, d, 1'b1, 1'b0, '0);
	endtask : wr
	task automatic rd_chk(input string name, input logic [11:0] a, input logic [7:0] exp);
		cyc(a, 8'h00, 1'b0, 1'b1, '0);
		check(name, rdata, exp);
	endtask : rd_chk
	task automatic wait_for(input logic want_irq, input logic want_gie);
		int i;
		for (i = 0; i < 20 && (irq_to_core !== want_irq ||
				global_interrupt_enable !== want_gie); i++) begin
			@(posedge ref_clk);
			#1;
		end
		if (i == 20) begin
			n_fail++;
			end_of_test();
		end
	endtask : wait_for
	// Enable globally, expect one vector, let the core ack it
	task automatic serve(input logic [4:0] vec);
		wr(12'hfcf, 8'h80);
		wait_for(1'b1, 1'b1);
		check("vector", {3'h0, irq_vector}, {3'h0, vec});
		wait_for(1'b0, 1'b0);
	endtask : serve
	initial begin
		repeat (16) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (int b = 0; b < 3; b++) begin
			rd_chk("reset", banks[b], 8'h00);
			wr(banks[b], 8'hff);
			rd_chk("sw set", banks[b], masks[b]);
			wr(banks[b], 8'h00);
			rd_chk("sw clear", banks[b], 8'h00);
		end
		rd_chk("unmapped", 12'hfc9, 8'h00);
		cyc(12'hfc9, 8'h00, 1'b0, 1'b0, '1);
		for (int b = 0; b < 3; b++) begin
			rd_chk("hw set", banks[b], masks[b]);
			wr(banks[b], 8'h00);
		end
		check("polled", {7'h0, irq_to_core}, 8'h00);
		cyc(12'hfc0, 8'h00, 1'b1, 1'b0, '{timer1: 1'b1, default: '0});
		rd_chk("hw wins", 12'hfc0, 8'h40);
		wr(12'hfc1, 8'h30);
		wr(12'hfc2, 8'h70);
		wr(12'hfc4, 8'h01);
		rd_chk("enable low", 12'hfc2, 8'h70);
		rd_chk("enable high", 12'hfc4, 8'h01);
		cyc(12'hfc9, 8'h00, 1'b0, 1'b0, '{timer0: 1'b1, serial_rx: 1'b1, converter: 1'b1,
			porta: 8'h01, default: '0});
		for (int k = 0; k < 4; k++) begin
			ack_delay <= (k < 2) ? 4'h0 : 4'h3;
			serve(order[k]);
		end
		wr(12'hfcf, 8'h80);
		repeat (2) @(posedge ref_clk);
		#1;
		check("disabled", {7'h0, irq_to_core}, 8'h00);
		rd_chk("acked0", 12'hfc0, 8'h01);
		rd_chk("acked1", 12'hfc3, 8'h00);
		wr(12'hfc0, 8'h00);
		@(posedge ref_clk);
		watchdog_req <= 1'b1;
		serve(5'h1e);
		serve(5'h1e);
		@(posedge ref_clk);
		watchdog_req <= 1'b0;
		wr(12'hfcf, 8'h80);
		repeat (6) @(posedge ref_clk);
		#1;
		check("wdog gone", {7'h0, irq_to_core}, 8'h00);
		rd_chk("control", 12'hfcf, 8'h80);
		end_of_test();
	end
endmodule : test_irl_top
`default_nettype wire
